/* ocf_pkg.sv */
// package: constants and types for the oscillator control and fail detect block
package ocf_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned WDT_FAIL_CYCLES = 8004; // system clocks with no watchdog-oscillator edge
  localparam logic [1:0] RST_STRETCH = 2'h3; // reset stretch cycles while the crystal settles

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_OSC_CTL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_OPTION = 8'h0c;

  // unlock bytes
  localparam logic [7:0] UNLOCK_KEY1 = 8'he7;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h18;

  // oscillator control fields
  localparam int unsigned CTL_INT_OSC_EN = 7;
  localparam int unsigned CTL_XTAL_EN = 6;
  localparam int unsigned CTL_WDT_OSC_EN = 5;
  localparam int unsigned CTL_PRI_FAIL_EN = 4;
  localparam int unsigned CTL_WDT_FAIL_EN = 3;
  localparam int unsigned CTL_SEL_LSB = 0;
  localparam logic [7:0] CTL_RESET = 8'ha0; // internal osc and wdt osc on, internal selected

  // primary oscillator select codes
  localparam logic [2:0] SEL_INT = 3'h0;
  localparam logic [2:0] SEL_XTAL = 3'h1;
  localparam logic [2:0] SEL_WDT = 3'h3;

  // status / mask bits
  localparam int unsigned ST_WDT_FAIL = 0;
  localparam int unsigned ST_HALTED = 1;
  localparam int unsigned ST_W = 2;

  // option byte
  localparam int unsigned OPT_XTAL_OFF_BIT = 4;
  localparam logic [7:0] OPT_RESERVED = 8'hef; // bits 7:5 and 3:0 read as ones
  localparam logic [7:0] OPT_RESET = 8'hff;

  typedef struct packed {
    logic int_osc_en;
    logic xtal_en;
    logic wdt_osc_en;
    logic pri_fail_en;
    logic wdt_osc_fail_detect_en;
    logic [2:0] sel;
  } ocf_ctl_t;

  typedef enum logic [1:0] {
    LK_LOCKED,
    LK_KEY1,
    LK_OPEN
  } ocf_lock_t;
endpackage

/* ocf_sync.sv */
// two-flop synchroniser for a level from another domain
module ocf_sync
  import ocf_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic ce_i, // clock enable
  input wire logic d_i, // asynchronous level
  output logic q_o // synchronised level
);
  logic s1_r;
  logic s2_r;

  // ----------------------------------------
  // flops; first stage read only by second
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else if (ce_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end

  assign q_o = s2_r;
endmodule

/* ocf_wdt_mon.sv */
// watchdog-oscillator failure detector: counts system clocks between edges
module ocf_wdt_mon
  import ocf_pkg::*;
#(
  parameter int unsigned FAIL_CYCLES = WDT_FAIL_CYCLES
)
(
  input wire logic clk_i, // system clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic ce_i, // clock enable
  input wire logic active_i, // detector allowed to run
  input wire logic wdt_lvl_i, // synchronised wdt oscillator level
  output logic fail_o // one-cycle pulse on failure
);
  localparam int unsigned CW = $clog2(FAIL_CYCLES + 1);

  if (FAIL_CYCLES < 2) begin : g_bad_fail_cycles
    $error("FAIL_CYCLES too small");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic prev_r;
  logic prev_nxt;
  logic fail_r;
  logic fail_nxt;
  logic edge_seen;

  // ----------------------------------------
  // gap counter
  // ----------------------------------------
  assign edge_seen = wdt_lvl_i ^ prev_r;

  always_comb begin
    prev_nxt = wdt_lvl_i;
    fail_nxt = 1'b0;
    cnt_nxt = cnt_r;
    if (!active_i || edge_seen) begin
      cnt_nxt = '0;
    end else if (cnt_r == CW'(FAIL_CYCLES - 1)) begin
      fail_nxt = 1'b1;
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
      prev_r <= 1'b0;
      fail_r <= 1'b0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
      prev_r <= prev_nxt;
      fail_r <= fail_nxt;
    end
  end

  assign fail_o = fail_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_fail_needs_active;
    @(posedge clk_i) disable iff (!reset_n_i) fail_o |-> $past(active_i);
  endproperty
  a_fail_needs_active: assert property (p_fail_needs_active) else $error("failure while inactive");

  property p_edge_restarts;
    @(posedge clk_i) disable iff (!reset_n_i) (ce_i && edge_seen) |=> (cnt_r == '0);
  endproperty
  a_edge_restarts: assert property (p_edge_restarts) else $error("counter not cleared on edge");

  property p_fail_at_count;
    @(posedge clk_i) disable iff (!reset_n_i) fail_o |-> $past(cnt_r) == CW'(FAIL_CYCLES - 1);
  endproperty
  a_fail_at_count: assert property (p_fail_at_count) else $error("failure at wrong count");
endmodule

/* ocf_top.sv */
// oscillator control with unlock sequence and watchdog-oscillator failure detection
module ocf_top
  import ocf_pkg::*;
#(
  parameter int unsigned FAIL_CYCLES = WDT_FAIL_CYCLES
)
(
  input wire logic clk_i, // system clock, 10 MHz
  input wire logic reset_n_i, // power-on reset, async, active low
  input wire logic ce_i, // clock enable, freezes state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic wdt_osc_i, // watchdog oscillator clock, asynchronous
  output logic int_osc_en_o, // internal oscillator enable
  output logic xtal_en_o, // crystal oscillator enable
  output logic wdt_osc_en_o, // watchdog oscillator enable
  output logic pri_fail_en_o, // primary failure detect enable
  output logic [2:0] clk_sel_o, // primary oscillator select
  output logic in_reset_o, // reset sequence still running
  output logic nmi_o, // one-cycle non-maskable event pulse
  output logic halted_o, // device stopped until power-on reset
  output logic irq_o // level interrupt
);
  if (FAIL_CYCLES < 2) begin : g_bad_fail_cycles
    $error("FAIL_CYCLES too small");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  ocf_ctl_t ctl_r;
  ocf_ctl_t ctl_nxt;
  ocf_lock_t lock_r;
  ocf_lock_t lock_nxt;
  logic [ST_W-1:0] status_r;
  logic [ST_W-1:0] status_nxt;
  logic [ST_W-1:0] mask_r;
  logic [ST_W-1:0] mask_nxt;
  logic xtal_off_r;
  logic xtal_off_nxt;
  logic pri_dead_r;
  logic pri_dead_nxt;
  logic halted_r;
  logic halted_nxt;
  logic [1:0] rst_cnt_r;
  logic [1:0] rst_cnt_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wdt_lvl;
  logic wdt_fail;
  logic det_active;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  logic [ST_W-1:0] events;

  // decoding used for the error answer only; the read data path decodes paddr in its own case
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == OFS_OSC_CTL) || (a == OFS_STATUS) || (a == OFS_MASK) || (a == OFS_OPTION);
  endfunction

  function automatic logic [7:0] ctl_pack(input ocf_ctl_t c);
    return {c.int_osc_en, c.xtal_en, c.wdt_osc_en, c.pri_fail_en, c.wdt_osc_fail_detect_en, c.sel};
  endfunction

  // ----------------------------------------
  // apb handshake: zero wait states
  // ----------------------------------------
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);

  // ----------------------------------------
  // watchdog oscillator sampling and detector
  // ----------------------------------------
  ocf_sync u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .d_i(wdt_osc_i),
    .q_o(wdt_lvl)
  );

  // inoperative when wdt osc is primary or off; gated further once the device has halted
  assign det_active = ctl_r.wdt_osc_fail_detect_en && ctl_r.wdt_osc_en
                      && (ctl_r.sel != SEL_WDT) && !halted_r;

  ocf_wdt_mon #(
    .FAIL_CYCLES(FAIL_CYCLES)
  ) u_mon (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .active_i(det_active),
    .wdt_lvl_i(wdt_lvl),
    .fail_o(wdt_fail)
  );

  // ----------------------------------------
  // control register and unlock sequence
  // ----------------------------------------
  // a wrong byte in the sequence drops back to locked, so a stray write cannot arm it
  always_comb begin
    ctl_nxt = ctl_r;
    lock_nxt = lock_r;
    if (wr && paddr == OFS_OSC_CTL) begin
      unique case (lock_r)
        LK_LOCKED: begin
          lock_nxt = (wbyte == UNLOCK_KEY1) ? LK_KEY1 : LK_LOCKED;
        end
        LK_KEY1: begin
          lock_nxt = (wbyte == UNLOCK_KEY2) ? LK_OPEN : LK_LOCKED;
        end
        LK_OPEN: begin
          ctl_nxt = ocf_ctl_t'(wbyte);
          lock_nxt = LK_LOCKED;
        end
        default: begin
          lock_nxt = LK_LOCKED;
        end
      endcase
    end
    // the select field is only ever written by software, never by a failure
    ctl_nxt.sel = (wr && paddr == OFS_OSC_CTL && lock_r == LK_OPEN) ? wbyte[2:0] : ctl_r.sel;
    // after a watchdog failure the primary detect can never be turned back on
    if (pri_dead_r || wdt_fail) begin
      ctl_nxt.pri_fail_en = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_r <= ocf_ctl_t'(CTL_RESET);
      lock_r <= LK_LOCKED;
    end else if (ce_i) begin
      ctl_r <= ctl_nxt;
      lock_r <= lock_nxt;
    end
  end

  // ----------------------------------------
  // failure bookkeeping and halt
  // ----------------------------------------
  always_comb begin
    pri_dead_nxt = pri_dead_r || wdt_fail;
    // no clock running and no detector to recover: only power-on reset helps
    halted_nxt = halted_r || (!ctl_r.int_osc_en && !ctl_r.xtal_en && !ctl_r.wdt_osc_en
                              && !ctl_r.pri_fail_en && !ctl_r.wdt_osc_fail_detect_en);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pri_dead_r <= 1'b0;
      halted_r <= 1'b0;
    end else if (ce_i) begin
      pri_dead_r <= pri_dead_nxt;
      halted_r <= halted_nxt;
    end
  end

  // ----------------------------------------
  // crystal reset option
  // ----------------------------------------
  // crystal kept on through reset lengthens the reset by a short settle count
  always_comb begin
    xtal_off_nxt = xtal_off_r;
    if (wr && paddr == OFS_OPTION) begin
      xtal_off_nxt = wbyte[OPT_XTAL_OFF_BIT];
    end
    // crystal off at reset: no settle wait, the stretch ends at the first edge
    if (rst_cnt_r == RST_STRETCH && xtal_off_r) begin
      rst_cnt_nxt = '0;
    end else begin
      rst_cnt_nxt = (rst_cnt_r != '0) ? rst_cnt_r - 2'h1 : rst_cnt_r;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xtal_off_r <= OPT_RESET[OPT_XTAL_OFF_BIT];
      rst_cnt_r <= RST_STRETCH;
    end else if (ce_i) begin
      xtal_off_r <= xtal_off_nxt;
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  // ----------------------------------------
  // status, mask, read data
  // ----------------------------------------
  assign events = {halted_nxt && !halted_r, wdt_fail};

  // set wins over the read clear
  always_comb begin
    status_nxt = status_r;
    if (rd && paddr == OFS_STATUS) begin
      status_nxt = '0;
    end
    status_nxt = status_nxt | events;
    mask_nxt = (wr && paddr == OFS_MASK) ? wbyte[ST_W-1:0] : mask_r;
    rdata_nxt = '0;
    if (psel && !penable) begin
      unique case (paddr)
        OFS_OSC_CTL: rdata_nxt = {24'h000000, ctl_pack(ctl_r)};
        OFS_STATUS: rdata_nxt = {30'h00000000, status_r};
        OFS_MASK: rdata_nxt = {30'h00000000, mask_r};
        OFS_OPTION: rdata_nxt = {24'h000000, OPT_RESERVED | {3'h0, xtal_off_r, 4'h0}};
        default: rdata_nxt = '0;
      endcase
    end else begin
      rdata_nxt = rdata_r;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_r <= '0;
      mask_r <= '0;
      rdata_r <= '0;
    end else if (ce_i) begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = rdata_r;
  // crystal runs if software enabled it or the reset option keeps it on
  assign int_osc_en_o = ctl_r.int_osc_en;
  assign xtal_en_o = ctl_r.xtal_en || (in_reset_o && !xtal_off_r);
  assign wdt_osc_en_o = ctl_r.wdt_osc_en;
  assign pri_fail_en_o = ctl_r.pri_fail_en;
  assign clk_sel_o = ctl_r.sel;
  assign in_reset_o = (rst_cnt_r != 2'h0);
  assign nmi_o = wdt_fail;
  assign halted_o = halted_r;
  assign irq_o = |(status_r & mask_r);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_locked_ignores;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ce_i && wr && paddr == OFS_OSC_CTL && lock_r != LK_OPEN && !wdt_fail) |=> $stable(ctl_r);
  endproperty
  a_locked_ignores: assert property (p_locked_ignores) else $error("locked register changed");

  property p_relock;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ce_i && wr && paddr == OFS_OSC_CTL && lock_r == LK_OPEN) |=> (lock_r == LK_LOCKED);
  endproperty
  a_relock: assert property (p_relock) else $error("register not relocked");

  property p_no_switch;
    @(posedge clk_i) disable iff (!reset_n_i) wdt_fail |=> $stable(clk_sel_o) || $past(wr);
  endproperty
  a_no_switch: assert property (p_no_switch) else $error("clock switched on failure");

  property p_nmi_status;
    @(posedge clk_i) disable iff (!reset_n_i) (ce_i && nmi_o) |=> status_r[ST_WDT_FAIL];
  endproperty
  a_nmi_status: assert property (p_nmi_status) else $error("failure event not recorded");

  property p_pri_dead;
    @(posedge clk_i) disable iff (!reset_n_i) pri_dead_r |-> !pri_fail_en_o;
  endproperty
  a_pri_dead: assert property (p_pri_dead) else $error("primary detect after wdt failure");

  property p_halt_sticky;
    @(posedge clk_i) disable iff (!reset_n_i) halted_o |=> halted_o;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("halt released without reset");

  property p_option_ones;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ce_i && psel && !penable && paddr == OFS_OPTION) |=> (prdata[7:0] | 8'h10) == 8'hff;
  endproperty
  a_option_ones: assert property (p_option_ones) else $error("reserved option bits not ones");

  property p_det_off_wdt_sel;
    @(posedge clk_i) disable iff (!reset_n_i) (clk_sel_o == SEL_WDT || !wdt_osc_en_o) |-> !det_active;
  endproperty
  a_det_off_wdt_sel: assert property (p_det_off_wdt_sel) else $error("detector active when unusable");

  property p_key1_advance;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ce_i && wr && paddr == OFS_OSC_CTL && lock_r == LK_LOCKED && wbyte == UNLOCK_KEY1) |=> (lock_r == LK_KEY1);
  endproperty
  a_key1_advance: assert property (p_key1_advance) else $error("first key not taken");

  property p_bad_key2;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ce_i && wr && paddr == OFS_OSC_CTL && lock_r == LK_KEY1 && wbyte != UNLOCK_KEY2) |=> (lock_r == LK_LOCKED);
  endproperty
  a_bad_key2: assert property (p_bad_key2) else $error("wrong second key left register armed");

  property p_open_stores;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ce_i && wr && paddr == OFS_OSC_CTL && lock_r == LK_OPEN)
        |=> (ctl_r.sel == $past(wbyte[2:0])) && (ctl_r.xtal_en == $past(wbyte[CTL_XTAL_EN]));
  endproperty
  a_open_stores: assert property (p_open_stores) else $error("unlocked write not stored");

  property p_read_clears;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ce_i && rd && paddr == OFS_STATUS && events == '0) |=> (status_r == '0);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared by read");

  property p_nmi_one_cycle;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ce_i && nmi_o) |=> !nmi_o;
  endproperty
  a_nmi_one_cycle: assert property (p_nmi_one_cycle) else $error("failure event longer than one cycle");

  property p_halt_all_off;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ce_i && !ctl_r.int_osc_en && !ctl_r.xtal_en && !ctl_r.wdt_osc_en && !ctl_r.pri_fail_en
        && !ctl_r.wdt_osc_fail_detect_en) |=> halted_o;
  endproperty
  a_halt_all_off: assert property (p_halt_all_off) else $error("all clocks off but not halted");

  property p_short_stretch;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ce_i && rst_cnt_r == RST_STRETCH && xtal_off_r) |=> !in_reset_o;
  endproperty
  a_short_stretch: assert property (p_short_stretch) else $error("reset stretched with crystal off");
endmodule

/* ocf_tb_top.sv */
// self-checking testbench for the oscillator control and fail detect block
module ocf_tb_top
  import ocf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  localparam int unsigned FC = 20; // shortened gap so the run stays brief
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic wdt_osc_i = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, int_osc_en_o, xtal_en_o, wdt_osc_en_o, pri_fail_en_o;
  logic [2:0] clk_sel_o;
  logic in_reset_o, nmi_o, halted_o, irq_o;
  int err_count = 0;
  int cmp_count = 0;
  int nmi_cnt = 0;
  logic nmi_prev = 1'b0;
  logic [31:0] rd;
  logic er;
  int gap;

  ocf_top #(.FAIL_CYCLES(FC)) ocf_top_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdt_osc_i(wdt_osc_i), .int_osc_en_o(int_osc_en_o),
    .xtal_en_o(xtal_en_o), .wdt_osc_en_o(wdt_osc_en_o), .pri_fail_en_o(pri_fail_en_o),
    .clk_sel_o(clk_sel_o), .in_reset_o(in_reset_o), .nmi_o(nmi_o), .halted_o(halted_o),
    .irq_o(irq_o)
  );

  // 10 MHz system clock
  always #50 clk_i = ~clk_i;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      err_count++;
      test_done();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, rd, er);
    check(rd, {24'h0, exp});
    check({31'h0, er}, 32'h0);
  endtask

  // key pair then the real value
  task automatic unlock_wr(input logic [7:0] d);
    wr(OFS_OSC_CTL, UNLOCK_KEY1);
    wr(OFS_OSC_CTL, UNLOCK_KEY2);
    wr(OFS_OSC_CTL, d);
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    check({31'h0, in_reset_o}, 32'h1);
    check({31'h0, xtal_en_o}, 32'h0);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check({31'h0, in_reset_o}, 32'h0);
    nmi_cnt = 0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // event pulse counter; a pulse must last exactly one cycle
  always @(posedge clk_i) begin
    if (nmi_o === 1'b1) nmi_cnt++;
    if (nmi_o === 1'b1 && nmi_prev === 1'b1) check({31'h0, nmi_o}, 32'h0);
    nmi_prev <= nmi_o;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int n;
    do_reset();
    // reset values of registers and outputs
    rd_chk(OFS_OSC_CTL, CTL_RESET);
    rd_chk(OFS_STATUS, 8'h00);
    rd_chk(OFS_MASK, 8'h00);
    rd_chk(OFS_OPTION, OPT_RESET);
    check({26'h0, int_osc_en_o, xtal_en_o, wdt_osc_en_o, clk_sel_o}, 32'h28);
    // locked writes, keys in the wrong order, wrong second key
    wr(OFS_OSC_CTL, 8'he8);
    rd_chk(OFS_OSC_CTL, CTL_RESET);
    wr(OFS_OSC_CTL, UNLOCK_KEY2);
    wr(OFS_OSC_CTL, UNLOCK_KEY1);
    wr(OFS_OSC_CTL, 8'he8);
    rd_chk(OFS_OSC_CTL, CTL_RESET);
    // good unlock, then relock; detect left off so no failure count starts here
    unlock_wr(8'he0);
    rd_chk(OFS_OSC_CTL, 8'he0);
    check({31'h0, xtal_en_o}, 32'h1);
    wr(OFS_OSC_CTL, 8'h88);
    rd_chk(OFS_OSC_CTL, 8'he0);
    // detector idle with watchdog osc as primary, then with it disabled
    unlock_wr(8'hab);
    idle(4 * FC);
    check(nmi_cnt, 0);
    unlock_wr(8'h8b);
    idle(4 * FC);
    check(nmi_cnt, 0);
    // software keeps the rule: detect enable cleared with watchdog osc as primary
    unlock_wr(8'ha3);
    idle(4 * FC);
    check(nmi_cnt, 0);
    check({29'h0, clk_sel_o}, {29'h0, SEL_WDT});
    // crystal primary, detector armed; edges keep restarting the gap count
    unlock_wr(8'he9);
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      wdt_osc_i <= ~wdt_osc_i;
      idle(FC - 6);
    end
    check(nmi_cnt, 0);
    // pin stays still now; the last toggle lies FC - 5 edges before the first look
    for (n = 0; n < 200; n++) begin
      @(posedge clk_i);
      if (nmi_o === 1'b1) break;
    end
    // gap from the pin toggle: FC clocks plus sync stages and the registered pulse
    gap = n + FC - 5;
    check({31'h0, gap >= FC && gap <= FC + 5}, 32'h1);
    idle(1);
    check(nmi_cnt, 1);
    check({29'h0, clk_sel_o}, {29'h0, SEL_XTAL});
    rd_chk(OFS_OSC_CTL, 8'he9);
    // status bit is masked, then unmasked, then cleared by the read
    check({31'h0, irq_o}, 32'h0);
    wr(OFS_MASK, 8'h01);
    idle(1);
    check({31'h0, irq_o}, 32'h1);
    rd_chk(OFS_STATUS, 8'h01);
    idle(1);
    check({31'h0, irq_o}, 32'h0);
    rd_chk(OFS_STATUS, 8'h00);
    // primary failure detect cannot be turned on after a watchdog failure
    unlock_wr(8'hf9);
    idle(1);
    check({31'h0, pri_fail_en_o}, 32'h0);
    // unmapped address is refused
    apb(1'b0, 8'h10, 8'h00, rd, er);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    // everything off stops the device until power-on reset
    do_reset();
    check({31'h0, halted_o}, 32'h0);
    unlock_wr(8'h00);
    idle(2);
    check({31'h0, halted_o}, 32'h1);
    rd_chk(OFS_STATUS, 8'h02);
    idle(FC * 3);
    check({31'h0, halted_o}, 32'h1);
    do_reset();
    check({31'h0, halted_o}, 32'h0);
    check({29'h0, clk_sel_o}, {29'h0, SEL_INT});
    check({31'h0, xtal_en_o}, 32'h0);
    // option byte: reserved bits written and read as ones
    wr(OFS_OPTION, 8'hef);
    rd_chk(OFS_OPTION, OPT_RESERVED);
    wr(OFS_OPTION, 8'hff);
    rd_chk(OFS_OPTION, 8'hff);
    check({29'h0, clk_sel_o}, {29'h0, SEL_INT});
    // clock enable low freezes state: a mask write in that time is lost
    ce_i <= 1'b0;
    wr(OFS_MASK, 8'h03);
    ce_i <= 1'b1;
    rd_chk(OFS_MASK, 8'h00);
    wr(OFS_MASK, 8'h03);
    rd_chk(OFS_MASK, 8'h03);
    test_done();
  end
endmodule
